// ===== emr_regs.sv
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Function
// - a completed PHY read stores the returned value in the data field.
// - turnaround field must be binary 10 (not checked: a frame with any other value still starts) and reads back exactly as written.
// - operation field 10 means PHY read, 01 means PHY write.
// - any other operation value makes the management frame invalid.
// - register address field selects the register inside the PHY.
// - pause count drops by one every 512 bit times.
// - reading the pause register returns the live countdown value.
// - lower hash register holds hash vector bits 31:0.
// - upper hash register holds hash vector bits 63:32.
// - each lower match register holds the low 32 address bits.
// - bit 0 of each lower match register is the group flag.
// - bit 0 maps to the lsb of the first received address byte.
// - type compare value is checked against received type/length field.
// - management-done flag sets when a management operation finishes.
// - pause-zero flag sets when the pause count reaches zero.
module emr_regs
  import emr_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // management serial pins
  output logic             O_MDC,
  input  wire logic        I_MDIO,
  output logic             O_MDIO,
  output logic             O_MDIO_OE,
  // link timing and receive side
  input  wire logic        I_PAUSE_LOAD,
  input  wire logic [15:0] I_PAUSE_VALUE,
  input  wire logic [47:0] I_RX_DEST_ADDR,
  input  wire logic [15:0] I_RX_TYPE_LEN,
  // filter results, management busy and interrupt
  output logic      [63:0] O_HASH_VECTOR,
  output logic      [3:0]  O_ADDR_MATCH,
  output logic      [3:0]  O_ADDR_GROUP,
  output logic             O_TYPE_MATCH,
  output logic             O_MGMT_BUSY,
  output logic             O_IRQ
);

  logic [31:0]          mgmt_frame;
  logic [15:0]          pause_count;
  logic [8:0]           quantum_cnt;
  logic [63:0]          hash_vec;
  logic [31:0]          match_low [MATCH_COUNT];
  logic [15:0]          match_high [MATCH_COUNT];
  logic [15:0]          type_compare_value;
  logic [IRQ_WIDTH-1:0] irq_stat;
  logic [IRQ_WIDTH-1:0] irq_en;
  logic [7:0]           mdc_div;
  logic [7:0]           div_cnt;
  emr_mg_state_t        mg_state;
  logic [5:0]           bit_cnt;
  logic [31:0]          shift_out;
  logic [15:0]          shift_in;
  logic                 is_read;
  logic                 mdio_s1;
  logic                 mdio_s2;
  logic                 mdio_s3;
  logic                 mdio_in;
  logic                 mdc_rise;
  logic                 mdc_fall;
  logic                 wr_en;
  logic                 rd_en;
  logic                 mgmt_done_ev;
  logic                 pause_zero_ev;
  logic                 bad_frame_ev;
  logic                 start_mgmt;
  logic [IRQ_WIDTH-1:0] irq_ev;
  logic [IRQ_WIDTH-1:0] irq_clr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] match_ofs(input int n, input logic hi);
    match_ofs = OFS_MATCH_BASE + 8'(n) * MATCH_STRIDE + (hi ? 8'h04 : 8'h00);
  endfunction

  assign wr_en     = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_en     = I_PSEL && I_PENABLE && !I_PWRITE;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = 1'b0;
  // write starts a frame only when idle; writes while busy are ignored
  assign start_mgmt = wr_en && hit(I_PADDR, OFS_MGMT_FRAME) && (mg_state == MG_IDLE);
  assign bad_frame_ev = start_mgmt && (I_PWDATA[SOF_HI:SOF_LO] != SOF_VALID ||
    (I_PWDATA[OP_HI:OP_LO] != OP_READ && I_PWDATA[OP_HI:OP_LO] != OP_WRITE));

  // configuration registers
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      hash_vec           <= '0;
      type_compare_value <= '0;
      irq_en             <= '0;
      mdc_div            <= MDC_DIV_RESET;
      for (int i = 0; i < MATCH_COUNT; i++)
      begin
        match_low[i]  <= '0;
        match_high[i] <= '0;
      end
    end
    else if (wr_en)
    begin
      if (hit(I_PADDR, OFS_HASH_LOW))
        hash_vec[31:0] <= I_PWDATA;
      if (hit(I_PADDR, OFS_HASH_HIGH))
        hash_vec[63:32] <= I_PWDATA;
      if (hit(I_PADDR, OFS_TYPE_CMP))
        type_compare_value <= I_PWDATA[15:0];
      if (hit(I_PADDR, OFS_IRQ_EN))
        irq_en <= I_PWDATA[IRQ_WIDTH-1:0];
      if (hit(I_PADDR, OFS_MGMT_DIV) && I_PWDATA[7:0] != 8'h00)
        mdc_div <= I_PWDATA[7:0];
      for (int i = 0; i < MATCH_COUNT; i++)
      begin
        if (hit(I_PADDR, match_ofs(i, 1'b0)))
          match_low[i] <= I_PWDATA;
        if (hit(I_PADDR, match_ofs(i, 1'b1)))
          match_high[i] <= I_PWDATA[15:0];
      end
    end
  end

  // pause countdown; software write wins over a received pause load
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pause_count <= '0;
      quantum_cnt <= '0;
    end
    else if (wr_en && hit(I_PADDR, OFS_PAUSE))
    begin
      pause_count <= I_PWDATA[15:0];
      quantum_cnt <= '0;
    end
    else if (I_PAUSE_LOAD)
    begin
      pause_count <= I_PAUSE_VALUE;
      quantum_cnt <= '0;
    end
    else if (pause_count != 16'h0000)
    begin
      if (quantum_cnt == 9'(PAUSE_QUANTUM_CYC - 1))
      begin
        quantum_cnt <= '0;
        pause_count <= pause_count - 16'h0001;
      end
      else
        quantum_cnt <= quantum_cnt + 9'h001;
    end
  end
  assign pause_zero_ev = (pause_count == 16'h0001) &&
    (quantum_cnt == 9'(PAUSE_QUANTUM_CYC - 1)) &&
    !(wr_en && hit(I_PADDR, OFS_PAUSE)) && !I_PAUSE_LOAD;

  // mdio input, three stages, change taken when stages two and three agree
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
      mdio_s3 <= 1'b1;
      mdio_in <= 1'b1;
    end
    else
    begin
      mdio_s1 <= I_MDIO;
      mdio_s2 <= mdio_s1;
      mdio_s3 <= mdio_s2;
      if (mdio_s2 == mdio_s3)
        mdio_in <= mdio_s3;
    end
  end

  // management clock divider, runs only during a frame
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      div_cnt <= '0;
      O_MDC   <= 1'b0;
    end
    else if (mg_state == MG_IDLE || mg_state == MG_DONE)
    begin
      div_cnt <= '0;
      O_MDC   <= 1'b0;
    end
    else if (div_cnt == mdc_div - 8'h01)
    begin
      div_cnt <= '0;
      O_MDC   <= !O_MDC;
    end
    else
      div_cnt <= div_cnt + 8'h01;
  end
  assign mdc_rise = (div_cnt == mdc_div - 8'h01) && !O_MDC;
  assign mdc_fall = (div_cnt == mdc_div - 8'h01) && O_MDC;

  // management frame engine: preamble, then the 32 frame bits msb first
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      mg_state  <= MG_IDLE;
      bit_cnt   <= '0;
      shift_out <= '0;
      shift_in  <= '0;
      is_read   <= 1'b0;
      O_MDIO    <= 1'b1;
      O_MDIO_OE <= 1'b0;
    end
    else
    begin
      case (mg_state)
        MG_IDLE:
        begin
          if (start_mgmt && !bad_frame_ev)
          begin
            // phy select and register select travel unchanged in the frame
            shift_out <= I_PWDATA;
            is_read   <= (I_PWDATA[OP_HI:OP_LO] == OP_READ);
            bit_cnt   <= '0;
            O_MDIO    <= 1'b1;
            O_MDIO_OE <= 1'b1;
            mg_state  <= MG_PRE;
          end
        end
        MG_PRE:
        begin
          if (mdc_fall)
          begin
            if (bit_cnt == PREAMBLE_BITS - 6'h01)
            begin
              bit_cnt   <= '0;
              O_MDIO    <= shift_out[31];
              shift_out <= {shift_out[30:0], 1'b0};
              mg_state  <= MG_SHIFT;
            end
            else
              bit_cnt <= bit_cnt + 6'h01;
          end
        end
        MG_SHIFT:
        begin
          if (mdc_rise && is_read && bit_cnt >= READ_DATA_POS)
            shift_in <= {shift_in[14:0], mdio_in};
          if (mdc_fall)
          begin
            if (bit_cnt == FRAME_BITS - 6'h01)
              mg_state <= MG_DONE;
            else
            begin
              bit_cnt   <= bit_cnt + 6'h01;
              O_MDIO    <= shift_out[31];
              shift_out <= {shift_out[30:0], 1'b0};
              // release the line for turnaround and data on reads
              if (is_read && bit_cnt + 6'h01 >= 6'(SOF_HI - TA_HI))
                O_MDIO_OE <= 1'b0;
            end
          end
        end
        MG_DONE:
        begin
          O_MDIO_OE <= 1'b0;
          O_MDIO    <= 1'b1;
          mg_state  <= MG_IDLE;
        end
        default:
          mg_state <= MG_IDLE;
      endcase
    end
  end
  assign mgmt_done_ev = (mg_state == MG_DONE);
  assign O_MGMT_BUSY  = (mg_state != MG_IDLE);

  // management frame register; data field takes the PHY value when a read completes
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      mgmt_frame <= '0;
    else if (start_mgmt)
      mgmt_frame <= I_PWDATA;
    else if (mgmt_done_ev && is_read)
      mgmt_frame[DAT_HI:0] <= shift_in;
  end

  always_comb
  begin
    irq_ev                 = '0;
    irq_ev[IRQ_MGMT_DONE]  = mgmt_done_ev;
    irq_ev[IRQ_PAUSE_ZERO] = pause_zero_ev;
    irq_ev[IRQ_BAD_FRAME]  = bad_frame_ev;
  end
  assign irq_clr = (wr_en && hit(I_PADDR, OFS_IRQ_CLR)) ? I_PWDATA[IRQ_WIDTH-1:0] : '0;

  // sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      irq_stat <= '0;
    else
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
  end
  assign O_IRQ = |(irq_stat & irq_en);

  // read data mux
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      O_PRDATA <= '0;
    else if (I_PSEL && !I_PENABLE && !I_PWRITE)
    begin
      O_PRDATA <= 32'h0000_0000;
      if (hit(I_PADDR, OFS_MGMT_FRAME))
        O_PRDATA <= mgmt_frame;
      if (hit(I_PADDR, OFS_PAUSE))
        O_PRDATA <= {16'h0000, pause_count};
      if (hit(I_PADDR, OFS_HASH_LOW))
        O_PRDATA <= hash_vec[31:0];
      if (hit(I_PADDR, OFS_HASH_HIGH))
        O_PRDATA <= hash_vec[63:32];
      if (hit(I_PADDR, OFS_TYPE_CMP))
        O_PRDATA <= {16'h0000, type_compare_value};
      if (hit(I_PADDR, OFS_IRQ_STAT))
        O_PRDATA <= {29'h0, irq_stat};
      if (hit(I_PADDR, OFS_IRQ_EN))
        O_PRDATA <= {29'h0, irq_en};
      if (hit(I_PADDR, OFS_MGMT_DIV))
        O_PRDATA <= {24'h000000, mdc_div};
      for (int i = 0; i < MATCH_COUNT; i++)
      begin
        if (hit(I_PADDR, match_ofs(i, 1'b0)))
          O_PRDATA <= match_low[i];
        if (hit(I_PADDR, match_ofs(i, 1'b1)))
          O_PRDATA <= {16'h0000, match_high[i]};
      end
    end
  end

  // receive-side compares, registered
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_HASH_VECTOR <= '0;
      O_ADDR_MATCH  <= '0;
      O_ADDR_GROUP  <= '0;
      O_TYPE_MATCH  <= 1'b0;
    end
    else
    begin
      O_HASH_VECTOR <= hash_vec;
      O_TYPE_MATCH  <= (type_compare_value != 16'h0000) &&
                       (I_RX_TYPE_LEN == type_compare_value);
      for (int i = 0; i < MATCH_COUNT; i++)
      begin
        // address bit 0 is the first bit of the first byte on the wire
        O_ADDR_MATCH[i] <= ({match_high[i], match_low[i]} == I_RX_DEST_ADDR);
        O_ADDR_GROUP[i] <= match_low[i][0];
      end
    end
  end

endmodule

// ===== emr_pkg.sv
package emr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MGMT_FRAME = 8'h34;
  localparam logic [7:0] OFS_PAUSE      = 8'h38;
  localparam logic [7:0] OFS_HASH_LOW   = 8'h90;
  localparam logic [7:0] OFS_HASH_HIGH  = 8'h94;
  localparam logic [7:0] OFS_MATCH_BASE = 8'h98;
  localparam logic [7:0] OFS_TYPE_CMP   = 8'hB8;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'hC0;
  localparam logic [7:0] OFS_IRQ_EN     = 8'hC4;
  localparam logic [7:0] OFS_IRQ_CLR    = 8'hC8;
  localparam logic [7:0] OFS_MGMT_DIV   = 8'hCC;
  localparam logic [7:0] MATCH_STRIDE   = 8'h08;
  localparam int         MATCH_COUNT    = 4;
  // management frame fields
  localparam int SOF_HI = 31;
  localparam int SOF_LO = 30;
  localparam int OP_HI  = 29;
  localparam int OP_LO  = 28;
  localparam int TA_HI  = 17;
  localparam int TA_LO  = 16;
  localparam int DAT_HI = 15;
  localparam logic [1:0] SOF_VALID = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] TA_CODE   = 2'h2;
  localparam logic [5:0] FRAME_BITS   = 6'h20;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] READ_DATA_POS = 6'h10;
  // irq bit positions
  localparam int IRQ_MGMT_DONE  = 0;
  localparam int IRQ_PAUSE_ZERO = 1;
  localparam int IRQ_BAD_FRAME  = 2;
  localparam int IRQ_WIDTH      = 3;
  // timing: 512 bit times at 100 Mb/s = 5120 ns
  localparam int PAUSE_QUANTUM_NS = 5120;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int PAUSE_QUANTUM_CYC = PAUSE_QUANTUM_NS / CLK_PERIOD_NS;
  localparam logic [7:0] MDC_DIV_RESET = 8'h14;
  typedef enum logic [1:0]
  {
    MG_IDLE  = 2'b00,
    MG_PRE   = 2'b01,
    MG_SHIFT = 2'b10,
    MG_DONE  = 2'b11
  } emr_mg_state_t;
endpackage

// ===== emr_regs_properties.sv
`timescale 1ns/100ps
module emr_props
  import emr_pkg::*;
(
  // watched ports
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        O_MDC,
  input wire logic        O_MDIO_OE,
  input wire logic [63:0] O_HASH_VECTOR,
  input wire logic [3:0]  O_ADDR_GROUP,
  input wire logic        O_MGMT_BUSY
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  wire logic       wr   = I_PSEL && I_PENABLE && I_PWRITE;
  wire logic [1:0] op   = I_PWDATA[OP_HI:OP_LO];
  wire logic       mg   = wr && I_PADDR == OFS_MGMT_FRAME && !O_MGMT_BUSY;
  wire logic       sof  = I_PWDATA[SOF_HI:SOF_LO] == SOF_VALID;
  wire logic       opok = op == OP_READ || op == OP_WRITE;

  ready_no_wait_a: assert property (I_PSEL |-> O_PREADY && !O_PSLVERR)
    else $error("apb slave stalled or flagged an error");
  frame_start_a: assert property (mg && sof && opok |=> O_MGMT_BUSY)
    else $error("valid management write did not start a frame");
  frame_length_a: assert property ($rose(O_MGMT_BUSY) |-> O_MGMT_BUSY [*8])
    else $error("management frame ended too early");
  bad_op_a: assert property (mg && !opok |=> !O_MGMT_BUSY)
    else $error("frame with invalid operation started");
  bad_start_a: assert property (mg && !sof |=> !O_MGMT_BUSY)
    else $error("frame with invalid start field started");
  idle_pins_a: assert property (mg && sof && opok |-> !O_MDC && !O_MDIO_OE)
    else $error("management pins not idle before a frame");
  hash_low_a: assert property (wr && I_PADDR == OFS_HASH_LOW
    |-> ##2 O_HASH_VECTOR[31:0] == $past(I_PWDATA, 2)) else $error("hash low mismatch");
  hash_high_a: assert property (wr && I_PADDR == OFS_HASH_HIGH
    |-> ##2 O_HASH_VECTOR[63:32] == $past(I_PWDATA, 2)) else $error("hash high mismatch");
  group_flag_a: assert property (wr && I_PADDR == OFS_MATCH_BASE
    |-> ##2 O_ADDR_GROUP[0] == $past(I_PWDATA[0], 2)) else $error("group flag mismatch");

  cover property (mg && sof && opok);
  cover property ($fell(O_MGMT_BUSY));
  cover property (wr && I_PADDR == OFS_PAUSE);
endmodule

bind emr_regs emr_props u_props
(
  .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_MDC(O_MDC), .O_MDIO_OE(O_MDIO_OE),
  .O_HASH_VECTOR(O_HASH_VECTOR), .O_ADDR_GROUP(O_ADDR_GROUP), .O_MGMT_BUSY(O_MGMT_BUSY)
);

// ===== emr_phy.sv
`timescale 1ns/100ps
module emr_phy
  import emr_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h03
)
(
  // management pins
  input  wire logic i_mdc,
  input  wire logic i_mdio,
  output logic      o_mdio    = 1'b1,
  output logic      o_mdio_oe = 1'b0
);
  logic [15:0] mem [32];
  logic [14:0] sh  = 15'h0000;
  logic [5:0]  cnt = 6'h00;
  logic [1:0]  op  = 2'h0;
  logic        hit = 1'b0;
  logic [4:0]  ra  = 5'h00;

  initial
  begin
    foreach (mem[i])
      mem[i] = 16'h0000;
  end

  // counting starts at the start bit, so any preamble length is accepted
  always @(posedge i_mdc)
  begin
    sh <= {sh[13:0], i_mdio};
    if (cnt == 6'h00 && i_mdio == 1'b0)
      cnt <= 6'h01;
    else if (cnt == 6'h20)
      cnt <= 6'h00;
    else if (cnt != 6'h00)
      cnt <= cnt + 6'h01;
    if (cnt == 6'h0E)
    begin
      op  <= sh[11:10];
      hit <= sh[9:5] == PHY_ADDR;
      ra  <= sh[4:0];
    end
    if (cnt == 6'h1F && hit && op == OP_WRITE)
      mem[ra] <= {sh, i_mdio};
  end

  // turnaround low, then data msb first; released otherwise so the pull-up wins
  always @(negedge i_mdc)
  begin
    o_mdio_oe <= hit && op == OP_READ && cnt >= 6'h0F && cnt < 6'h20;
    o_mdio    <= cnt == 6'h0F ? 1'b0 : mem[ra][4'(6'h1F - cnt)];
  end
endmodule

// ===== test_mac_phy_mgmt_pause_addr_regs.sv
`timescale 1ns/100ps
module test_mac_phy_mgmt_pause_addr_regs
  import emr_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pl = 1'b0;
  logic        mdc, mdo, moe, poe, pd, busy, irq, tm, rdy;
  logic [7:0]  pa = 8'h00;
  logic [7:0]  ofs [7] = '{OFS_MGMT_FRAME, OFS_PAUSE, OFS_HASH_LOW, OFS_MATCH_BASE,
                           OFS_TYPE_CMP, OFS_IRQ_STAT, 8'hFC};
  logic [31:0] pw = 32'h0, prd, rv, r1, seed = 32'h00012F6C, v [10];
  logic [15:0] rt = 16'h0000, d, pv = 16'h0000;
  logic [47:0] rdest = 48'h0;
  logic [63:0] hv;
  logic [3:0]  am, ag;
  int          bad_count = 0, n_checks = 0, cyc = 0, clash = 0;
  wire logic   mdio_w = moe ? mdo : (poe ? pd : 1'b1);

  always #5 clk = ~clk;

  emr_regs uut
  (
    .I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(pa), .I_PWDATA(pw), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(),
    .O_MDC(mdc), .I_MDIO(mdio_w), .O_MDIO(mdo), .O_MDIO_OE(moe), .I_PAUSE_LOAD(pl),
    .I_PAUSE_VALUE(pv), .I_RX_DEST_ADDR(rdest), .I_RX_TYPE_LEN(rt),
    .O_HASH_VECTOR(hv), .O_ADDR_MATCH(am), .O_ADDR_GROUP(ag), .O_TYPE_MATCH(tm),
    .O_MGMT_BUSY(busy), .O_IRQ(irq)
  );
  emr_phy u_phy (.i_mdc(mdc), .i_mdio(mdio_w), .o_mdio(pd), .o_mdio_oe(poe));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] frm(logic [1:0] s, logic [1:0] o, logic [15:0] dt);
    return {s, o, 5'h03, 5'h09, TA_CODE, dt};
  endfunction
  // upper match words only carry 16 address bits
  function automatic logic [31:0] msk(int i);
    return (i > 2 && i % 2 == 1) ? 32'h0000FFFF : 32'hFFFFFFFF;
  endfunction

  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] dt);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pw   <= dt;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1)
      @(posedge clk);
    rv = prd;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic idle();
    repeat (3) @(posedge clk);
    while (busy !== 1'b0)
      @(posedge clk);
    @(posedge clk);
  endtask
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    // both ends driving the data line at once is a turnaround fault
    if (moe && poe)
      clash++;
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[i])
    begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset value", 64'h0, rv);
    end
    for (int i = 0; i < 10; i++)
    begin
      v[i] = xs();
      apb(1'b1, OFS_HASH_LOW + 8'(4 * i), v[i]);
      apb(1'b0, OFS_HASH_LOW + 8'(4 * i), 32'h0);
      chk("readback", v[i] & msk(i), rv & msk(i));
    end
    chk("hash vector", {v[1], v[0]}, hv);
    for (int n = 0; n < 4; n++)
    begin
      rdest <= {v[3 + 2 * n][15:0], v[2 + 2 * n]};
      repeat (3) @(posedge clk);
      chk("address match", 64'(4'h1 << n), am);
      chk("group flag", v[2 + 2 * n][0], ag[n]);
    end
    apb(1'b1, OFS_TYPE_CMP, 32'h00000800);
    rt <= 16'h0800;
    repeat (3) @(posedge clk);
    chk("type match", 64'h1, tm);
    rt <= 16'h0801;
    repeat (3) @(posedge clk);
    chk("type mismatch", 64'h0, tm);
    apb(1'b1, OFS_MGMT_DIV, 32'h00000008);
    apb(1'b1, OFS_IRQ_EN, 32'h00000007);
    d = v[4][31:16];
    apb(1'b1, OFS_MGMT_FRAME, frm(SOF_VALID, OP_WRITE, d));
    idle();
    chk("phy register", d, u_phy.mem[9]);
    chk("done irq", 64'h1, irq);
    apb(1'b1, OFS_IRQ_CLR, 32'h00000001);
    @(posedge clk);
    chk("irq cleared", 64'h0, irq);
    apb(1'b1, OFS_MGMT_FRAME, frm(SOF_VALID, OP_READ, 16'h0000));
    idle();
    apb(1'b0, OFS_MGMT_FRAME, 32'h0);
    chk("read data", d, rv[DAT_HI:0]);
    chk("turnaround", TA_CODE, rv[TA_HI:TA_LO]);
    chk("mdio contention", 64'h0, 64'(clash));
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, OFS_MGMT_FRAME, frm(j == 2 ? 2'h3 : SOF_VALID, 2'(3 * j), 16'h0000));
      @(posedge clk);
      chk("refused frame", 64'h0, busy);
    end
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("status", 64'h5, rv);
    apb(1'b1, OFS_IRQ_EN, 32'h00000000);
    @(posedge clk);
    chk("irq masked", 64'h0, irq);
    apb(1'b1, OFS_IRQ_CLR, 32'h00000007);
    apb(1'b1, OFS_IRQ_EN, 32'h00000002);
    apb(1'b1, OFS_PAUSE, 32'h00000003);
    apb(1'b0, OFS_PAUSE, 32'h0);
    r1 = rv;
    chk("pause start", 64'h3, r1);
    // reads 512 cycles apart see exactly one step whatever the prescaler phase
    repeat (509) @(posedge clk);
    apb(1'b0, OFS_PAUSE, 32'h0);
    chk("pause step", 64'h2, rv);
    repeat (1200) @(posedge clk);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("pause zero", 64'h2, rv);
    chk("pause irq", 64'h1, irq);
    pv <= v[5][15:0] | 16'h0100;
    pl <= 1'b1;
    @(posedge clk);
    pl <= 1'b0;
    apb(1'b0, OFS_PAUSE, 32'h0);
    chk("pause load", 64'(pv), rv);
    conclude();
  end
endmodule
